// *** rtl/ops_consts.svh ***
// Timing counts and control bit positions for the output path sequencer
`ifndef OPS_CONSTS_SVH
`define OPS_CONSTS_SVH

// Clock period in ns
`define OPS_CLK_NS        40
// Least time from supply present to power-down pin release, ns
`define OPS_SUPPLY_NS     150
// Least settle time from input path switch to output power, ns
`define OPS_SETTLE_NS     2000000
// Timer and age counter width
`define OPS_TW            20

// Control bit positions in the control word
`define OPS_B_VCM         0
`define OPS_B_PLL         1
`define OPS_B_DAC         2
`define OPS_B_MASTER_CLOCK_OUTPUT_ENABLE        3
`define OPS_B_DAC_LEFT_TO_LINE_SWITCH        4
`define OPS_B_DAC_RIGHT_TO_LINE_SWITCH        5
`define OPS_B_DAC_LEFT_TO_MONO_SWITCH        6
`define OPS_B_DAC_RIGHT_TO_MONO_SWITCH        7
`define OPS_B_DAC_LEFT_TO_HEADPHONE_SWITCH       8
`define OPS_B_DAC_RIGHT_TO_HEADPHONE_SWITCH       9
`define OPS_B_LO          10
`define OPS_B_MO          11
`define OPS_B_HPL         12
`define OPS_B_HPR         13
`define OPS_B_UNMUTE      14
`define OPS_B_IN1HL       15
`define OPS_B_IN1L        16
`define OPS_B_IN1M        17
`define OPS_CW            18

// Reset value of the control word: everything off
`define OPS_CTRL_RST      18'h00000

`endif

// *** rtl/ops_pkg.sv ***
// Types shared by the output path sequencer files
package ops_pkg;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_OFF,
    ST_SUPPLY,
    ST_PDN,
    ST_LOCK,
    ST_SWITCH,
    ST_SETTLE,
    ST_POWER,
    ST_ON,
    ST_MUTE,
    ST_GROUND,
    ST_OUT_OFF,
    ST_SW_OFF,
    ST_DOWN
  } ops_state_t;

  // Path selection as presented on the command port
  typedef enum logic [2:0] {
    PATH_DAC_LINE = 3'h0,
    PATH_DAC_MONO = 3'h1,
    PATH_DAC_HP   = 3'h2,
    PATH_IN_HP    = 3'h3,
    PATH_IN_LINE  = 3'h4,
    PATH_IN_MONO  = 3'h5
  } ops_path_t;

  // Control word driven to the device
  typedef logic [17:0] ops_ctrl_t;

endpackage

// *** rtl/ops_sequencer.sv ***
// Host sequencer ordering power-up and power-down of the output paths
`timescale 1ns/1ps
`include "ops_consts.svh"

module ops_sequencer
  import ops_pkg::*;
#(
  parameter int SETTLE_CYC = (`OPS_SETTLE_NS + `OPS_CLK_NS - 1) / `OPS_CLK_NS
)
(
  input  wire logic                clock_i,
  input  wire logic                srst_i,
  input  wire logic                power_up_i,
  input  wire logic                power_down_i,
  input  wire logic                pll_slave_i,
  input  wire logic [2:0]          path_sel_i,
  input  wire logic [`OPS_TW-1:0]  lock_cycles_i,
  input  wire logic                slow_attenuator_i,
  input  wire logic                supply_good_i,
  input  wire logic                headphones_grounded_i,
  output logic                     power_down_n_pin_o,
  output logic                     common_voltage_power_o,
  output logic                     pll_power_o,
  output logic                     dac_power_o,
  output logic                     master_clock_output_enable_o,
  output logic                     dac_left_to_line_switch_o,
  output logic                     dac_right_to_line_switch_o,
  output logic                     dac_left_to_mono_switch_o,
  output logic                     dac_right_to_mono_switch_o,
  output logic                     dac_left_to_headphone_switch_o,
  output logic                     dac_right_to_headphone_switch_o,
  output logic                     line_out_power_o,
  output logic                     mono_out_power_o,
  output logic                     headphone_left_power_o,
  output logic                     headphone_right_power_o,
  output logic                     headphone_unmute_o,
  output logic                     input1_left_to_headphone_switch_o,
  output logic                     input1_left_to_line_switch_o,
  output logic                     input1_left_to_mono_switch_o,
  output logic                     attenuator_transition_select_o,
  output logic                     ext_clocks_run_o,
  output logic                     busy_o,
  output logic                     path_on_o,
  output logic                     cmd_error_o
);

  // Least supply-present wait in cycles, rounded up
  localparam int SUPPLY_CYC = (`OPS_SUPPLY_NS + `OPS_CLK_NS - 1) / `OPS_CLK_NS;

  // Saturating increment for age counters
  function automatic logic [`OPS_TW-1:0] sat_inc(
    input logic [`OPS_TW-1:0] v
  );
    sat_inc = (&v) ? v : v + 20'h00001;
  endfunction

  // Path switch bits for a path
  function automatic ops_ctrl_t switch_mask(input ops_path_t p);
    switch_mask = '0;
    case (p)
      PATH_DAC_LINE: begin
        switch_mask[`OPS_B_DAC_LEFT_TO_LINE_SWITCH] = 1'b1;
        switch_mask[`OPS_B_DAC_RIGHT_TO_LINE_SWITCH] = 1'b1;
      end
      PATH_DAC_MONO: begin
        switch_mask[`OPS_B_DAC_LEFT_TO_MONO_SWITCH] = 1'b1;
        switch_mask[`OPS_B_DAC_RIGHT_TO_MONO_SWITCH] = 1'b1;
      end
      PATH_DAC_HP: begin
        switch_mask[`OPS_B_DAC_LEFT_TO_HEADPHONE_SWITCH] = 1'b1;
        switch_mask[`OPS_B_DAC_RIGHT_TO_HEADPHONE_SWITCH] = 1'b1;
      end
      PATH_IN_HP:   switch_mask[`OPS_B_IN1HL] = 1'b1;
      PATH_IN_LINE: switch_mask[`OPS_B_IN1L] = 1'b1;
      PATH_IN_MONO: switch_mask[`OPS_B_IN1M] = 1'b1;
      default:      switch_mask = '0;
    endcase
  endfunction

  // Output power bits for a path; DAC power joins for the DAC line and mono paths in external mode
  function automatic ops_ctrl_t power_mask(input ops_path_t p,
                                           input logic pll);
    power_mask = '0;
    case (p)
      PATH_DAC_LINE: begin
        power_mask[`OPS_B_LO]  = 1'b1;
        power_mask[`OPS_B_DAC] = !pll;
      end
      PATH_DAC_MONO: begin
        power_mask[`OPS_B_MO]  = 1'b1;
        power_mask[`OPS_B_DAC] = 1'b1;
      end
      PATH_DAC_HP, PATH_IN_HP: begin
        power_mask[`OPS_B_HPL]    = 1'b1;
        power_mask[`OPS_B_HPR]    = 1'b1;
        power_mask[`OPS_B_UNMUTE] = 1'b1;
      end
      PATH_IN_LINE: power_mask[`OPS_B_LO] = 1'b1;
      PATH_IN_MONO: power_mask[`OPS_B_MO] = 1'b1;
      default:      power_mask = '0;
    endcase
  endfunction

  ops_state_t          state_q, state_d;   // Sequencer state
  ops_ctrl_t           ctrl_q, ctrl_d;     // Control word to device
  logic                pdn_q, pdn_d;       // Power-down pin level
  ops_path_t           path_q, path_d;     // Latched path
  logic                pll_q, pll_d;       // Latched PLL slave mode
  logic [`OPS_TW-1:0]  lock_q, lock_d;     // Latched lock wait
  logic                err_q, err_d;       // Command refused pulse
  logic                ats_q;              // Attenuator select bit
  logic                sup_m_q, sup_q;     // Supply synchroniser
  logic                gnd_m_q, gnd_q;     // Ground detect synchroniser
  logic                tmr_start;          // Start a wait
  logic [`OPS_TW-1:0]  tmr_load;           // Wait length
  logic                tmr_done;           // Wait over
  logic [`OPS_TW-1:0]  sup_age_q;          // Cycles of supply present
  logic [`OPS_TW-1:0]  sw_age_q;           // Cycles since switches set
  logic [`OPS_TW-1:0]  pll_age_q;          // Cycles since PLL power

  // Command decode
  wire ops_path_t req_path = ops_path_t'(path_sel_i);
  wire req_ok = pll_slave_i
              ? (req_path == PATH_DAC_HP || req_path == PATH_DAC_LINE)
              : (path_sel_i <= 3'h5 && req_path != PATH_DAC_HP);
  wire hp_path  = (path_q == PATH_DAC_HP) || (path_q == PATH_IN_HP);
  wire analog   = (path_q == PATH_IN_HP) || (path_q == PATH_IN_LINE) ||
                  (path_q == PATH_IN_MONO);
  wire settle   = analog || (path_q == PATH_DAC_HP);
  wire [`OPS_TW-1:0] lock_req = (lock_cycles_i == '0) ? 20'h00001
                                                       : lock_cycles_i;
  wire [`OPS_TW-1:0] settle_ld = `OPS_TW'(SETTLE_CYC);
  wire [`OPS_TW-1:0] supply_ld = `OPS_TW'(SUPPLY_CYC);
  wire ops_ctrl_t sw_bits  = switch_mask(path_q);
  wire ops_ctrl_t pwr_bits = power_mask(path_q, pll_q);

  // Wait timer shared by supply, lock and settle waits
  ops_timer u_ops_timer (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .start_i (tmr_start),
    .load_i  (tmr_load),
    .done_o  (tmr_done)
  );

  // Pin inputs through two flops
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sup_m_q <= 1'b0;
      sup_q   <= 1'b0;
      gnd_m_q <= 1'b0;
      gnd_q   <= 1'b0;
    end else begin
      sup_m_q <= supply_good_i;
      sup_q   <= sup_m_q;
      gnd_m_q <= headphones_grounded_i;
      gnd_q   <= gnd_m_q;
    end
  end

  // Next state and control word
  always_comb begin
    state_d   = state_q;
    ctrl_d    = ctrl_q;
    pdn_d     = pdn_q;
    path_d    = path_q;
    pll_d     = pll_q;
    lock_d    = lock_q;
    err_d     = 1'b0;
    tmr_start = 1'b0;
    tmr_load  = supply_ld;
    unique case (state_q)
      ST_OFF: begin
        // Take a power-up order only with valid path and supply
        if (power_up_i && req_ok && sup_q) begin
          path_d    = req_path;
          pll_d     = pll_slave_i;
          lock_d    = lock_req;
          tmr_start = 1'b1;
          state_d   = ST_SUPPLY;
        end else if (power_up_i) begin
          err_d = 1'b1;
        end
      end
      ST_SUPPLY: begin
        // Supply lost: back off
        if (!sup_q) begin
          state_d = ST_OFF;
        end else if (tmr_done) begin
          pdn_d   = 1'b1;
          state_d = ST_PDN;
        end
      end
      ST_PDN: begin
        ctrl_d[`OPS_B_VCM] = 1'b1;
        if (pll_q) begin
          ctrl_d[`OPS_B_PLL]  = 1'b1;
          ctrl_d[`OPS_B_DAC]  = 1'b1;
          ctrl_d[`OPS_B_MASTER_CLOCK_OUTPUT_ENABLE] = 1'b1;
          tmr_start = 1'b1;
          tmr_load  = lock_q;
          state_d   = ST_LOCK;
        end else begin
          state_d = ST_SWITCH;
        end
      end
      ST_LOCK: begin
        // Switches only once the lock wait is over
        if (tmr_done) begin
          state_d = ST_SWITCH;
        end
      end
      ST_SWITCH: begin
        ctrl_d = ctrl_q | sw_bits;
        if (settle) begin
          tmr_start = 1'b1;
          tmr_load  = settle_ld;
          state_d   = ST_SETTLE;
        end else begin
          state_d = ST_POWER;
        end
      end
      ST_SETTLE: begin
        if (tmr_done) begin
          state_d = ST_POWER;
        end
      end
      ST_POWER: begin
        ctrl_d  = ctrl_q | pwr_bits;
        state_d = ST_ON;
      end
      ST_ON: begin
        if (power_down_i) begin
          state_d = hp_path ? ST_MUTE : ST_OUT_OFF;
        end
      end
      ST_MUTE: begin
        // Mute starts the headphone ramp to ground
        ctrl_d[`OPS_B_UNMUTE] = 1'b0;
        state_d = ST_GROUND;
      end
      ST_GROUND: begin
        if (gnd_q) begin
          state_d = ST_OUT_OFF;
        end
      end
      ST_OUT_OFF: begin
        // Output power and DAC off, clocks may then stop
        ctrl_d = ctrl_q & ~pwr_bits;
        ctrl_d[`OPS_B_DAC] = 1'b0;
        state_d = ST_SW_OFF;
      end
      ST_SW_OFF: begin
        ctrl_d  = ctrl_q & ~sw_bits;
        state_d = ST_DOWN;
      end
      ST_DOWN: begin
        ctrl_d  = `OPS_CTRL_RST;
        pdn_d   = 1'b0;
        state_d = ST_OFF;
      end
    endcase
  end

  // State and control registers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_q <= ST_OFF;
      ctrl_q  <= `OPS_CTRL_RST;
      pdn_q   <= 1'b0;
      path_q  <= PATH_DAC_LINE;
      pll_q   <= 1'b0;
      lock_q  <= 20'h00001;
      err_q   <= 1'b0;
      ats_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      ctrl_q  <= ctrl_d;
      pdn_q   <= pdn_d;
      path_q  <= path_d;
      pll_q   <= pll_d;
      lock_q  <= lock_d;
      err_q   <= err_d;
      ats_q   <= slow_attenuator_i;
    end
  end

  // Age counters watched by the checks
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sup_age_q <= '0;
      sw_age_q  <= '0;
      pll_age_q <= '0;
    end else begin
      sup_age_q <= sup_q ? sat_inc(sup_age_q) : '0;
      sw_age_q  <= (|(ctrl_q & sw_bits)) ? sat_inc(sw_age_q) : '0;
      pll_age_q <= ctrl_q[`OPS_B_PLL] ? sat_inc(pll_age_q) : '0;
    end
  end

  // Outputs to the device pins and bits
  assign power_down_n_pin_o              = pdn_q;
  assign common_voltage_power_o          = ctrl_q[`OPS_B_VCM];
  assign pll_power_o                     = ctrl_q[`OPS_B_PLL];
  assign dac_power_o                     = ctrl_q[`OPS_B_DAC];
  assign master_clock_output_enable_o    = ctrl_q[`OPS_B_MASTER_CLOCK_OUTPUT_ENABLE];
  assign dac_left_to_line_switch_o       = ctrl_q[`OPS_B_DAC_LEFT_TO_LINE_SWITCH];
  assign dac_right_to_line_switch_o      = ctrl_q[`OPS_B_DAC_RIGHT_TO_LINE_SWITCH];
  assign dac_left_to_mono_switch_o       = ctrl_q[`OPS_B_DAC_LEFT_TO_MONO_SWITCH];
  assign dac_right_to_mono_switch_o      = ctrl_q[`OPS_B_DAC_RIGHT_TO_MONO_SWITCH];
  assign dac_left_to_headphone_switch_o  = ctrl_q[`OPS_B_DAC_LEFT_TO_HEADPHONE_SWITCH];
  assign dac_right_to_headphone_switch_o = ctrl_q[`OPS_B_DAC_RIGHT_TO_HEADPHONE_SWITCH];
  assign line_out_power_o                = ctrl_q[`OPS_B_LO];
  assign mono_out_power_o                = ctrl_q[`OPS_B_MO];
  assign headphone_left_power_o          = ctrl_q[`OPS_B_HPL];
  assign headphone_right_power_o         = ctrl_q[`OPS_B_HPR];
  assign headphone_unmute_o              = ctrl_q[`OPS_B_UNMUTE];
  assign input1_left_to_headphone_switch_o = ctrl_q[`OPS_B_IN1HL];
  assign input1_left_to_line_switch_o    = ctrl_q[`OPS_B_IN1L];
  assign input1_left_to_mono_switch_o    = ctrl_q[`OPS_B_IN1M];
  assign attenuator_transition_select_o  = ats_q;
  // Clocks requested exactly while the DAC is powered
  assign ext_clocks_run_o                = ctrl_q[`OPS_B_DAC];
  assign busy_o    = (state_q != ST_OFF) && (state_q != ST_ON);
  assign path_on_o = (state_q == ST_ON);
  assign cmd_error_o = err_q;

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  pdn_release_a: assert property (
    $rose(pdn_q) |-> sup_age_q >= `OPS_TW'(SUPPLY_CYC))
    else $error("pin released before supply wait");

  vcm_after_pin_a: assert property (
    $rose(ctrl_q[`OPS_B_VCM]) |-> $past(pdn_q) && ctrl_q[`OPS_B_VCM] &&
      (ctrl_q & sw_bits) == '0)
    else $error("common voltage out of order");

  switch_after_vcm_a: assert property (
    $rose(|(ctrl_q & sw_bits)) |-> $past(ctrl_q[`OPS_B_VCM]))
    else $error("switch set before common voltage");

  dac_after_switch_a: assert property (
    $rose(ctrl_q[`OPS_B_DAC]) && !pll_q |->
      $past(ctrl_q[`OPS_B_DAC_LEFT_TO_LINE_SWITCH] && ctrl_q[`OPS_B_DAC_RIGHT_TO_LINE_SWITCH]) ||
      $past(ctrl_q[`OPS_B_DAC_LEFT_TO_MONO_SWITCH] && ctrl_q[`OPS_B_DAC_RIGHT_TO_MONO_SWITCH]))
    else $error("DAC powered before its switches");

  settle_wait_a: assert property (
    $rose(ctrl_q[`OPS_B_HPL] || ctrl_q[`OPS_B_LO] || ctrl_q[`OPS_B_MO])
      && settle |-> sw_age_q >= `OPS_TW'(SETTLE_CYC))
    else $error("output power before settle time");

  hp_off_ground_a: assert property (
    $fell(ctrl_q[`OPS_B_HPL]) |-> $past(gnd_q) ##1
      $fell(|(ctrl_q & sw_bits)))
    else $error("headphone off out of order");

  pll_group_a: assert property (
    $rose(ctrl_q[`OPS_B_PLL]) |-> pdn_q && ctrl_q[`OPS_B_VCM] &&
      ctrl_q[`OPS_B_DAC] && ctrl_q[`OPS_B_MASTER_CLOCK_OUTPUT_ENABLE])
    else $error("PLL bits not set together");

  lock_wait_a: assert property (
    $rose(|(ctrl_q & sw_bits)) && pll_q |-> pll_age_q >= lock_q)
    else $error("switches before lock wait");

  refuse_pulse_a: assert property (
    state_q == ST_OFF && power_up_i && !req_ok |=> cmd_error_o ##1
      !cmd_error_o)
    else $error("refused order not flagged");

  cover_ext_line_c: cover property (
    state_q == ST_POWER && path_q == PATH_DAC_LINE && !pll_q ##1 path_on_o);
  cover_pll_hp_c: cover property (
    state_q == ST_LOCK && path_q == PATH_DAC_HP ##[1:1000] path_on_o);
  cover_hp_down_c: cover property (
    state_q == ST_GROUND ##[1:1000] state_q == ST_OUT_OFF);

endmodule

// *** rtl/ops_timer.sv ***
// One-shot wait timer used by the output path sequencer
`timescale 1ns/1ps
`include "ops_consts.svh"

module ops_timer
  import ops_pkg::*;
(
  input  wire logic                 clock_i,
  input  wire logic                 srst_i,
  input  wire logic                 start_i,
  input  wire logic [`OPS_TW-1:0]   load_i,
  output logic                      done_o
);

  logic [`OPS_TW-1:0] cnt_q;   // Remaining cycles
  logic               busy_q;  // Wait in progress

  // Done in the last counted cycle
  assign done_o = busy_q && (cnt_q == 20'h00001);

  // Load, count down, stop
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      busy_q <= 1'b0;
      cnt_q  <= '0;
    end else if (start_i) begin
      busy_q <= 1'b1;
      cnt_q  <= load_i;
    end else if (done_o) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 20'h00001;
    end
  end

  // A one-cycle load ends in the next cycle
  timer_short_a: assert property (@(posedge clock_i) disable iff (srst_i)
    start_i && load_i == 20'h00001 |=> done_o)
    else $error("timer short wait wrong");

  // Done is a single pulse
  timer_pulse_a: assert property (@(posedge clock_i) disable iff (srst_i)
    done_o && !start_i |=> !done_o)
    else $error("timer done held too long");

endmodule

// *** testbench/ops_device_model.sv ***
// Behavioural device model: takes the control bits, flags order faults
`timescale 1ns/1ps

module ops_device_model #(
  parameter int LOCK = 5,  // Cycles the model's PLL needs to lock
  parameter int FALL = 6   // Cycles for headphone outputs to reach ground
) (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        supply_i,
  input  wire logic [18:0] ctl_i,
  output logic             grounded_o,
  output logic             mclk_out_o,
  output logic             violation_o
);
  localparam int GROUP_DELAY = 22;   // Samples from input to output
  localparam int ATT_DEFAULT = 1061; // Default attenuator ramp

  logic [18:0] p_q;    // Control bits seen at the last edge
  int          sup_q;  // Edges with supply present
  int          lock_q; // Edges since PLL power on
  int          gnd_q;  // Edges since unmute dropped
  wire logic [18:0] up_w = ctl_i & ~p_q;
  wire logic [18:0] dn_w = ~ctl_i & p_q;

  // Outputs ramp down with or without clocks
  assign grounded_o = (gnd_q == FALL);
  // Clock out only once locked
  assign mclk_out_o = ctl_i[14] && (lock_q >= LOCK);

  // Track state and flag any control order fault
  always @(posedge clock_i) begin
    if (srst_i) begin
      p_q         <= '0;
      sup_q       <= 0;
      lock_q      <= 0;
      gnd_q       <= FALL;
      violation_o <= 1'b0;
    end else begin
      p_q    <= ctl_i;
      sup_q  <= supply_i ? sup_q + 1 : 0;
      lock_q <= ctl_i[16] ? lock_q + 1 : 0;
      gnd_q  <= ctl_i[3] ? 0 : ((gnd_q < FALL) ? gnd_q + 1 : FALL);
      if (up_w[18] && sup_q < 4) violation_o <= 1'b1;
      if (!ctl_i[18] && |ctl_i[17:0]) violation_o <= 1'b1;
      if ((|up_w[13:8] || |up_w[2:0]) && !ctl_i[17])
        violation_o <= 1'b1;
      if (up_w[15] && !ctl_i[16] && !(&ctl_i[13:12] || &ctl_i[11:10]))
        violation_o <= 1'b1;
      if (up_w[7] && !(&ctl_i[13:12]) && !ctl_i[1])
        violation_o <= 1'b1;
      if (up_w[6] && !(&ctl_i[11:10]) && !ctl_i[0])
        violation_o <= 1'b1;
      if (|up_w[5:3] && !(&ctl_i[9:8]) && !ctl_i[2])
        violation_o <= 1'b1;
      if (|up_w[13:8] && ctl_i[16] && lock_q < LOCK)
        violation_o <= 1'b1;
      if (|dn_w[5:4] && !grounded_o) violation_o <= 1'b1;
      if ((dn_w[9] || dn_w[8] || dn_w[2]) && |ctl_i[5:4])
        violation_o <= 1'b1;
    end
  end
endmodule

// *** testbench/output_path_power_sequencer_tb.sv ***
// Self-checking bench for the output path sequencer
`timescale 1ns/1ps
`include "ops_consts.svh"

module output_path_power_sequencer_tb;
  import ops_pkg::*;
  localparam int SETTLE = 8; // Shortened settle wait
  localparam int LOCK   = 5; // Lock time of the model's PLL; the design gets LOCK + i in up()

  logic clock_i, srst_i, power_up_i, power_down_i, pll_slave_i;
  logic [2:0] path_sel_i;
  logic slow_attenuator_i, supply_good_i, gnd, mclk, viol;
  logic pin, vcm, pll, dac, master_clock_output_enable, dac_left_to_line_switch, dac_right_to_line_switch, dac_left_to_mono_switch, dac_right_to_mono_switch, dac_left_to_headphone_switch, dac_right_to_headphone_switch;
  logic lo, mo, headphone_left_output, headphone_right_output, unm, inhl, inl, inm, atts, ecr, busy, pon, cerr;
  int fail_count, n_tests, cyc_q;
  logic [19:0] lock_cyc; // Lock wait handed to the design
  // Pin and all control word bits in one vector
  wire logic [18:0] ctl = {pin, vcm, pll, dac, master_clock_output_enable, dac_left_to_line_switch, dac_right_to_line_switch, dac_left_to_mono_switch, dac_right_to_mono_switch,
                           dac_left_to_headphone_switch, dac_right_to_headphone_switch, lo, mo, headphone_left_output, headphone_right_output, unm, inhl, inl, inm};
  // Cases: path, mode, expected bits, least switch-to-power gap
  logic [2:0]  t_path [7] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h0, 3'h2};
  logic        t_pll  [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic [18:0] t_exp  [7] = '{19'h6B080, 19'h68C40, 19'h6003C, 19'h60082,
                              19'h60041, 19'h7F080, 19'h7C338};
  int          t_gap  [7] = '{1, 1, SETTLE, SETTLE, SETTLE, 1, SETTLE};

  ops_sequencer #(.SETTLE_CYC(SETTLE)) u_ops_sequencer (
    .clock_i(clock_i), .srst_i(srst_i), .power_up_i(power_up_i),
    .power_down_i(power_down_i), .pll_slave_i(pll_slave_i),
    .path_sel_i(path_sel_i), .lock_cycles_i(lock_cyc),
    .slow_attenuator_i(slow_attenuator_i), .supply_good_i(supply_good_i),
    .headphones_grounded_i(gnd), .power_down_n_pin_o(pin),
    .common_voltage_power_o(vcm), .pll_power_o(pll), .dac_power_o(dac),
    .master_clock_output_enable_o(master_clock_output_enable),
    .dac_left_to_line_switch_o(dac_left_to_line_switch), .dac_right_to_line_switch_o(dac_right_to_line_switch),
    .dac_left_to_mono_switch_o(dac_left_to_mono_switch), .dac_right_to_mono_switch_o(dac_right_to_mono_switch),
    .dac_left_to_headphone_switch_o(dac_left_to_headphone_switch),
    .dac_right_to_headphone_switch_o(dac_right_to_headphone_switch),
    .line_out_power_o(lo), .mono_out_power_o(mo),
    .headphone_left_power_o(headphone_left_output), .headphone_right_power_o(headphone_right_output),
    .headphone_unmute_o(unm), .input1_left_to_headphone_switch_o(inhl),
    .input1_left_to_line_switch_o(inl), .input1_left_to_mono_switch_o(inm),
    .attenuator_transition_select_o(atts), .ext_clocks_run_o(ecr),
    .busy_o(busy), .path_on_o(pon), .cmd_error_o(cerr));

  ops_device_model #(.LOCK(LOCK), .FALL(6)) u_ops_device_model (
    .clock_i(clock_i), .srst_i(srst_i), .supply_i(supply_good_i),
    .ctl_i(ctl), .grounded_o(gnd), .mclk_out_o(mclk), .violation_o(viol));

  // Free-running clock
  always #20 clock_i = ~clock_i;

  // Hang guard
  always @(posedge clock_i) begin
    cyc_q <= cyc_q + 1;
    if (cyc_q == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // Compare and count
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One-cycle power-up order
  task automatic order(input logic [2:0] pth, input logic pm);
    @(negedge clock_i);
    path_sel_i = pth;
    pll_slave_i = pm;
    power_up_i = 1'b1;
    @(negedge clock_i);
    power_up_i = 1'b0;
  endtask

  // Refused order: exactly one error pulse, nothing started
  task automatic refuse(input logic [2:0] pth, input logic pm);
    int k, hits;
    hits = 0;
    order(pth, pm);
    for (k = 0; k < 4; k++) begin
      hits += int'(cerr === 1'b1);
      @(negedge clock_i);
    end
    check(19'(hits), 19'h00001);
    check({17'h00000, busy, pin}, 19'h00000);
  endtask

  // Power up one path, timing its steps
  task automatic up(input int i);
    int n, tp, ts, tw;
    tp = -1;
    ts = -1;
    tw = -1;
    // Lock wait differs from case to case
    lock_cyc = 20'(LOCK + i);
    order(t_path[i], t_pll[i]);
    for (n = 0; n < 300 && pon !== 1'b1; n++) begin
      if (pll === 1'b1 && tp < 0) tp = n;
      if ((|ctl[13:8] || |ctl[2:0]) && ts < 0) ts = n;
      if ((lo || mo || headphone_left_output) && tw < 0) tw = n;
      @(negedge clock_i);
    end
    if (tw < 0) tw = n;
    check(ctl, t_exp[i]);
    check(19'(ecr), 19'(t_exp[i][15]));
    check(19'(mclk), 19'(t_pll[i]));
    check(19'(tw - ts >= t_gap[i]), 19'h00001);
    if (t_pll[i]) check(19'(ts - tp >= int'(lock_cyc)), 19'h00001);
  endtask

  // Power down and wait for the pin to fall
  task automatic down();
    int n;
    @(negedge clock_i);
    power_down_i = 1'b1;
    @(negedge clock_i);
    power_down_i = 1'b0;
    for (n = 0; n < 300 && (busy !== 1'b0 || pin !== 1'b0); n++)
      @(negedge clock_i);
    check({ctl[18:1], pon}, 19'h00000);
  endtask

  // Main sequence
  initial begin
    int i;
    clock_i = 1'b0;
    srst_i = 1'b1;
    {power_up_i, power_down_i, pll_slave_i} = 3'h0;
    path_sel_i = 3'h0;
    slow_attenuator_i = 1'b0;
    lock_cyc = 20'(LOCK);
    supply_good_i = 1'b0;
    fail_count = 0;
    n_tests = 0;
    cyc_q = 0;
    repeat (8) @(negedge clock_i);
    srst_i = 1'b0;
    check(ctl, 19'h00000);
    check({18'h00000, busy}, 19'h00000);
    refuse(3'h0, 1'b0);
    supply_good_i = 1'b1;
    repeat (3) @(negedge clock_i);
    refuse(3'h2, 1'b0);
    refuse(3'h3, 1'b1);
    refuse(3'h6, 1'b0);
    down();
    for (i = 0; i < 7; i++) begin
      slow_attenuator_i = i[0];
      up(i);
      check(19'(atts), 19'(i[0]));
      down();
    end
    // Supply lost inside the release wait
    order(3'h0, 1'b0);
    supply_good_i = 1'b0;
    repeat (12) @(negedge clock_i);
    check({17'h00000, pin, busy}, 19'h00000);
    check(19'(viol), 19'h00000);
    report_and_stop();
  end
endmodule
